// File: hdl/acss_pkg.sv
// Package for the combined ADC and comparator acquisition sequencer.
// Assumes one 125 MHz core clock; times are given in ns and converted to cycle counts.
package acss_pkg;

	// Register byte offsets (Avalon-MM word addresses times four)
	localparam logic [7:0] ACSS_CTRL_OFS   = 8'h00; // acquisition_control_reg
	localparam logic [7:0] ACSS_CFG_OFS    = 8'h04; // acquisition_configuration_reg
	localparam logic [7:0] ACSS_POL_OFS    = 8'h08; // input_polarity_control_reg
	localparam logic [7:0] ACSS_ALERT_OFS  = 8'h0C; // alert enables and aux settle time
	localparam logic [7:0] ACSS_STAT_OFS   = 8'h10; // status
	localparam logic [7:0] ACSS_TIME_OFS   = 8'h14; // computed acquisition time in cycles
	localparam logic [7:0] ACSS_COEF_OFS   = 8'h18; // on-demand coefficient (read only)
	localparam logic [7:0] ACSS_FACT_OFS   = 8'h1C; // factory coefficient (read only)

	// Control register field positions
	localparam int ACSS_START_BIT  = 0;
	localparam int ACSS_TYPE_LSB   = 1;  // acquisition_type_field [2:1]
	localparam int ACSS_OVS_LSB    = 4;  // oversample_count_field [6:4]
	localparam int ACSS_SWEEP_BIT  = 7;  // cell_sweep_order_select
	localparam int ACSS_CALAPP_BIT = 8;  // calibration_apply_enable
	localparam int ACSS_DONE_BIT   = 0;  // acquisition_complete_flag in status

	// Acquisition types
	typedef enum logic [1:0] {
		ACSS_TYPE_ADC  = 2'h0,
		ACSS_TYPE_COMP = 2'h1,
		ACSS_TYPE_BOTH = 2'h2,
		ACSS_TYPE_CAL  = 2'h3
	} acss_type_t;

	// Times in ns and derived cycle counts
	localparam int ACSS_CLK_NS       = 8;
	localparam int ACSS_INIT_OVS_NS  = 15000;
	localparam int ACSS_INIT_ONE_NS  = 35000;
	localparam int ACSS_CELL_NS      = 9000;
	localparam int ACSS_BLK_NS       = 31500;
	localparam int ACSS_DTEMP_NS     = 33500;
	localparam int ACSS_VREF_NS      = 87750;
	localparam int ACSS_DAC_NS       = 20250;
	localparam int ACSS_DOTH_NS      = 5440;
	localparam int ACSS_AUX_NS       = 13500;
	localparam int ACSS_HVREC_NS     = 57000;
	localparam int ACSS_AUXSET_NS    = 6000;
	localparam int ACSS_CAL_NS       = 3750000;
	localparam int ACSS_INIT_OVS_CYC = ACSS_INIT_OVS_NS / ACSS_CLK_NS;
	localparam int ACSS_INIT_ONE_CYC = ACSS_INIT_ONE_NS / ACSS_CLK_NS;
	localparam int ACSS_CELL_CYC     = ACSS_CELL_NS / ACSS_CLK_NS;
	localparam int ACSS_BLK_CYC      = (ACSS_BLK_NS + ACSS_CLK_NS - 1) / ACSS_CLK_NS;
	localparam int ACSS_DTEMP_CYC    = (ACSS_DTEMP_NS + ACSS_CLK_NS - 1) / ACSS_CLK_NS;
	localparam int ACSS_VREF_CYC     = (ACSS_VREF_NS + ACSS_CLK_NS - 1) / ACSS_CLK_NS;
	localparam int ACSS_DAC_CYC      = (ACSS_DAC_NS + ACSS_CLK_NS - 1) / ACSS_CLK_NS;
	localparam int ACSS_DOTH_CYC     = ACSS_DOTH_NS / ACSS_CLK_NS;
	localparam int ACSS_AUX_CYC      = (ACSS_AUX_NS + ACSS_CLK_NS - 1) / ACSS_CLK_NS;
	localparam int ACSS_HVREC_CYC    = ACSS_HVREC_NS / ACSS_CLK_NS;
	localparam int ACSS_AUXSET_CYC   = ACSS_AUXSET_NS / ACSS_CLK_NS;
	localparam int ACSS_CAL_CYC      = ACSS_CAL_NS / ACSS_CLK_NS;

	// Diagnostic selection codes
	localparam logic [1:0] ACSS_DIAG_TEMP = 2'h0;
	localparam logic [1:0] ACSS_DIAG_VREF = 2'h1;
	localparam logic [1:0] ACSS_DIAG_DAC  = 2'h2;
	localparam logic [1:0] ACSS_DIAG_OTH  = 2'h3;

	// Reset values and coefficient constants
	localparam logic [31:0] ACSS_CFG_RST   = 32'h0000_0000;
	localparam logic [31:0] ACSS_FACT_COEF = 32'h0000_5A5A; // arbitrary factory coefficient
	localparam logic [31:0] ACSS_CAL_COEF  = 32'h0000_1234; // arbitrary computed coefficient

	// Configuration fields: cells [13:0], aux [19:14], block [20], diag en [21], diag sel [23:22],
	// thermistor mode [24], notch rate [26:25], aux settle [36:27] written and read only through alert reg [25:16]
	typedef struct packed {
		logic [9:0]  aux_settle_time_field;
		logic [1:0]  notch_rate_select;
		logic        thermistor_bias_mode;
		logic [1:0]  diag_sel;
		logic        diag_en;
		logic        block_voltage_measure_enable;
		logic [5:0]  aux_en;
		logic [13:0] cell_en;
	} acss_cfg_t;

	// Engine activity signals toward the analog front end
	typedef struct packed {
		logic adc_run;
		logic comp_run;
		logic pyramid;
		logic cal_src;
		logic hv_recover;
	} acss_eng_t;

	// Count enabled bits
	function automatic logic [4:0] acss_popcnt(input logic [13:0] v);
		logic [4:0] n;
		n = 5'h00;
		for (int i = 0; i < 14; i++) begin
			n = n + {4'h0, v[i]};
		end
		return n;
	endfunction : acss_popcnt

endpackage : acss_pkg

// File: hdl/acss_seq.sv
// Combined ADC and comparator acquisition sequencer with on-demand calibration.
// Assumes an Avalon-MM master on core_clk_in and an analog front end reading the engine outputs.
//
// The register offsets and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none

module acss_seq #(
	parameter int CAL_CYCLES = acss_pkg::ACSS_CAL_CYC // Calibration length in cycles
) (
	input  wire logic                core_clk_in,       // Core clock, 125 MHz
	input  wire logic                resetn_in,         // Synchronous reset, active low
	input  wire logic [7:0]          avs_address_in,    // Byte address
	input  wire logic                avs_read_in,       // Read request
	input  wire logic                avs_write_in,      // Write request
	input  wire logic [31:0]         avs_writedata_in,  // Write data
	input  wire logic [3:0]          avs_byteenable_in, // Byte enables
	output logic [31:0]              avs_readdata_out,  // Read data
	output logic                     avs_waitrequest_out, // Wait request
	output logic                     cmd_forward_out,   // Pulse: command passed down chain
	output acss_pkg::acss_eng_t      eng_out,           // Engine activity
	output logic [31:0]              coef_used_out      // Coefficient applied to results
);
	import acss_pkg::*;

	typedef enum logic [6:0] {
		ST_IDLE = 7'b000_0001,
		ST_INIT = 7'b000_0010,
		ST_BLK  = 7'b000_0100,
		ST_CELL = 7'b000_1000,
		ST_DIAG = 7'b001_0000,
		ST_AUX  = 7'b010_0000,
		ST_HV   = 7'b100_0000
	} acss_state_t;

	acss_state_t  state_q;
	acss_cfg_t    cfg_q;
	logic [31:0]  pol_q;
	logic [3:0]   alert_en_q;    // cell OV, cell UV, aux OV, aux UV
	logic [1:0]   type_q;
	logic [2:0]   ovs_q;
	logic         sweep_q;
	logic         cal_apply_q;
	logic         done_q;
	logic         cal_busy_q;
	logic         start_q;
	logic         ack_q;
	logic [31:0]  cnt_q;
	logic [7:0]   samp_left_q;
	logic [31:0]  coef_q;
	logic [31:0]  rdata_q;
	logic         fwd_q;
	logic [31:0]  acq_time_q;
	logic [31:0]  acq_time_d;
	logic [31:0]  cycle_time;
	logic [31:0]  init_time;
	logic [31:0]  settle_time;
	logic [31:0]  diag_time;
	logic [7:0]   samples;
	logic         req;
	logic         wr_acc;
	logic         cmd_ok;

	// Each request is answered one cycle after it is raised
	assign req                 = avs_read_in | avs_write_in;
	assign avs_waitrequest_out = req & ~ack_q;
	assign wr_acc              = avs_write_in & ack_q;
	assign cmd_ok              = wr_acc & ~cal_busy_q;
	assign avs_readdata_out    = rdata_q;
	assign cmd_forward_out     = fwd_q;

	always_ff @(posedge core_clk_in) begin
		if (!resetn_in) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= req & ~ack_q;
		end
	end

	// Every accepted write is forwarded, even when ignored during calibration
	always_ff @(posedge core_clk_in) begin
		if (!resetn_in) begin
			fwd_q <= 1'b0;
		end else begin
			fwd_q <= wr_acc;
		end
	end

	// Oversample code to sample count
	assign samples = 8'h01 << ((ovs_q == 3'h0) ? 3'h0 : 3'(ovs_q + 3'h1));

	// Acquisition time arithmetic
	always_comb begin
		diag_time = 32'h0;
		if (cfg_q.diag_en) begin
			unique case (cfg_q.diag_sel)
				ACSS_DIAG_TEMP: diag_time = 32'(ACSS_DTEMP_CYC);
				ACSS_DIAG_VREF: diag_time = 32'(ACSS_VREF_CYC);
				ACSS_DIAG_DAC:  diag_time = 32'(ACSS_DAC_CYC);
				ACSS_DIAG_OTH:  diag_time = 32'(ACSS_DOTH_CYC);
			endcase
		end
		init_time  = (samples > 8'h01) ? 32'(ACSS_INIT_OVS_CYC) : 32'(ACSS_INIT_ONE_CYC);
		cycle_time = 32'(acss_popcnt(cfg_q.cell_en)) * 32'(ACSS_CELL_CYC)
			+ (cfg_q.block_voltage_measure_enable ? 32'(ACSS_BLK_CYC) : 32'h0)
			+ diag_time
			+ 32'(acss_popcnt({8'h00, cfg_q.aux_en})) * 32'(ACSS_AUX_CYC);
		settle_time = 32'h0;
		if (cfg_q.thermistor_bias_mode && cfg_q.aux_en != 6'h00) begin
			settle_time = 32'(cfg_q.aux_settle_time_field) * 32'(ACSS_AUXSET_CYC);
			if (cfg_q.notch_rate_select == 2'h0) begin
				// Free run: earlier phases already count as settling
				if (settle_time > init_time + cycle_time) begin
					settle_time = settle_time - init_time - cycle_time;
				end else begin
					settle_time = 32'h0;
				end
			end
		end
		acq_time_d = init_time + settle_time + 32'(samples) * cycle_time
			+ 32'(samples - 8'h01) * 32'(ACSS_HVREC_CYC);
	end

	// Register writes; start strobes are never stored as readable state
	always_ff @(posedge core_clk_in) begin
		if (!resetn_in) begin
			cfg_q       <= acss_cfg_t'({5'h00, ACSS_CFG_RST}); // Settle field has no reset bits of its own
			pol_q       <= 32'h0;
			alert_en_q  <= 4'h0;
			type_q      <= ACSS_TYPE_ADC;
			ovs_q       <= 3'h0;
			sweep_q     <= 1'b0;
			cal_apply_q <= 1'b0;
			start_q     <= 1'b0;
		end else begin
			start_q <= 1'b0;
			if (cmd_ok && avs_address_in == ACSS_CTRL_OFS && avs_byteenable_in[0]) begin
				if (!done_q) begin
					type_q <= avs_writedata_in[ACSS_TYPE_LSB +: 2];
				end
				ovs_q   <= avs_writedata_in[ACSS_OVS_LSB +: 3];
				sweep_q <= avs_writedata_in[ACSS_SWEEP_BIT];
				start_q <= avs_writedata_in[ACSS_START_BIT] & (state_q == ST_IDLE);
			end
			if (cmd_ok && avs_address_in == ACSS_CTRL_OFS && avs_byteenable_in[1]) begin
				cal_apply_q <= avs_writedata_in[ACSS_CALAPP_BIT];
			end
			if (cmd_ok && avs_address_in == ACSS_CFG_OFS) begin
				cfg_q[21:0] <= avs_writedata_in[21:0];
				cfg_q[26:22] <= avs_writedata_in[26:22];
			end
			if (cmd_ok && avs_address_in == ACSS_POL_OFS) begin
				pol_q <= avs_writedata_in;
			end
			if (cmd_ok && avs_address_in == ACSS_ALERT_OFS) begin
				alert_en_q <= avs_writedata_in[3:0];
				cfg_q.aux_settle_time_field <= avs_writedata_in[25:16];
			end
		end
	end

	// Acquisition sequencer
	always_ff @(posedge core_clk_in) begin
		if (!resetn_in) begin
			state_q     <= ST_IDLE;
			cnt_q       <= 32'h0;
			samp_left_q <= 8'h00;
			cal_busy_q  <= 1'b0;
		end else begin
			unique case (state_q)
				ST_IDLE: begin
					if (start_q && type_q == ACSS_TYPE_CAL) begin
						cal_busy_q <= 1'b1;
						cnt_q      <= 32'(CAL_CYCLES) - 32'h1;
						state_q    <= ST_INIT;
					end else if (start_q) begin
						samp_left_q <= samples;
						cnt_q       <= init_time + settle_time - 32'h1;
						state_q     <= ST_INIT;
					end
				end
				ST_INIT: begin
					if (cnt_q != 32'h0) begin
						cnt_q <= cnt_q - 32'h1;
					end else if (cal_busy_q) begin
						cal_busy_q <= 1'b0;
						state_q    <= ST_IDLE;
					end else begin
						cnt_q   <= cfg_q.block_voltage_measure_enable ? 32'(ACSS_BLK_CYC) - 32'h1 : 32'h0;
						state_q <= ST_BLK;
					end
				end
				ST_BLK, ST_CELL, ST_DIAG, ST_AUX: begin
					if (cnt_q != 32'h0) begin
						cnt_q <= cnt_q - 32'h1;
					end else if (state_q == ST_BLK) begin
						cnt_q   <= 32'(acss_popcnt(cfg_q.cell_en)) * 32'(ACSS_CELL_CYC);
						state_q <= ST_CELL;
					end else if (state_q == ST_CELL) begin
						cnt_q   <= diag_time;
						state_q <= ST_DIAG;
					end else if (state_q == ST_DIAG) begin
						cnt_q   <= 32'(acss_popcnt({8'h00, cfg_q.aux_en})) * 32'(ACSS_AUX_CYC);
						state_q <= ST_AUX;
					end else if (samp_left_q > 8'h01) begin
						samp_left_q <= samp_left_q - 8'h01;
						cnt_q       <= 32'(ACSS_HVREC_CYC) - 32'h1;
						state_q     <= ST_HV;
					end else begin
						samp_left_q <= 8'h00;
						state_q     <= ST_IDLE;
					end
				end
				ST_HV: begin
					if (cnt_q != 32'h0) begin
						cnt_q <= cnt_q - 32'h1;
					end else begin
						state_q <= ST_BLK;
					end
				end
			endcase
		end
	end

	// Completion flag: set wins over a software clear in the same cycle
	always_ff @(posedge core_clk_in) begin
		if (!resetn_in) begin
			done_q <= 1'b0;
		end else if (state_q != ST_IDLE && cnt_q == 32'h0 &&
			(cal_busy_q || (state_q == ST_AUX && samp_left_q <= 8'h01))) begin
			done_q <= 1'b1;
		end else if (cmd_ok && avs_address_in == ACSS_STAT_OFS && avs_writedata_in[ACSS_DONE_BIT]) begin
			done_q <= 1'b0;
		end
	end

	// Coefficient store; factory value is a constant and has no write path
	always_ff @(posedge core_clk_in) begin
		if (!resetn_in) begin
			coef_q <= 32'h0;
		end else if (cal_busy_q && state_q == ST_INIT && cnt_q == 32'h0) begin
			coef_q <= ACSS_CAL_COEF;
		end
	end

	// Applied coefficient follows the apply bit only
	always_ff @(posedge core_clk_in) begin
		if (!resetn_in) begin
			coef_used_out <= ACSS_FACT_COEF;
		end else begin
			coef_used_out <= cal_apply_q ? coef_q : ACSS_FACT_COEF;
		end
	end

	// Latched duration for software inspection
	always_ff @(posedge core_clk_in) begin
		if (!resetn_in) begin
			acq_time_q <= 32'h0;
		end else if (start_q && type_q != ACSS_TYPE_CAL) begin
			acq_time_q <= acq_time_d;
		end
	end

	// Engine activity outputs; comparator gated per phase by the alert enables
	always_ff @(posedge core_clk_in) begin
		if (!resetn_in) begin
			eng_out <= '0;
		end else begin
			eng_out.cal_src    <= cal_busy_q;
			eng_out.adc_run    <= cal_busy_q || state_q inside {ST_BLK, ST_CELL, ST_DIAG, ST_AUX};
			eng_out.comp_run   <= !cal_busy_q && type_q == ACSS_TYPE_BOTH &&
				((state_q == ST_CELL && (alert_en_q[0] || alert_en_q[1])) ||
				 (state_q == ST_AUX && (alert_en_q[2] || alert_en_q[3])));
			eng_out.pyramid    <= (type_q == ACSS_TYPE_BOTH) ? 1'b1 : ~sweep_q;
			eng_out.hv_recover <= state_q == ST_HV;
		end
	end

	// Read data; unmapped addresses read zero, start bit reads zero
	always_ff @(posedge core_clk_in) begin
		if (!resetn_in) begin
			rdata_q <= 32'h0;
		end else if (avs_read_in && !ack_q) begin
			unique case (avs_address_in)
				ACSS_CTRL_OFS:  rdata_q <= {23'h0, cal_apply_q, sweep_q, ovs_q, 1'b0, type_q, 1'b0};
				ACSS_CFG_OFS:   rdata_q <= {5'h0, cfg_q[26:0]};
				ACSS_POL_OFS:   rdata_q <= pol_q;
				ACSS_ALERT_OFS: rdata_q <= {6'h0, cfg_q.aux_settle_time_field, 12'h0, alert_en_q};
				ACSS_STAT_OFS:  rdata_q <= {29'h0, cal_busy_q, state_q != ST_IDLE, done_q};
				ACSS_TIME_OFS:  rdata_q <= acq_time_q;
				ACSS_COEF_OFS:  rdata_q <= coef_q;
				ACSS_FACT_OFS:  rdata_q <= ACSS_FACT_COEF;
				default:        rdata_q <= 32'h0;
			endcase
		end
	end

endmodule : acss_seq

`default_nettype wire

// File: sim/acss_host_model.sv
// Host model: an Avalon-MM master standing in for the chain controller.
// Assumes the sequencer's clock; one transfer at a time.
`timescale 1ns/10ps
`default_nettype none
module acss_host_model (
	input  wire logic        clk_in,    // Core clock
	input  wire logic        wait_in,   // Slave wait request
	input  wire logic [31:0] rdata_in,  // Slave read data
	output logic      [7:0]  addr_out,  // Byte address
	output logic             rd_out,    // Read request
	output logic             wr_out,    // Write request
	output logic      [31:0] wdata_out, // Write data
	output logic      [3:0]  be_out     // Byte enables
);
	// Quiet bus from time zero
	initial begin
		addr_out = 8'h00;
		rd_out = 1'b0;
		wr_out = 1'b0;
		wdata_out = 32'h0;
		be_out = 4'h0;
	end
	// Request held until wait is seen low at an edge, then released
	task automatic xfer(input logic rnw, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] be, output logic [31:0] q);
		@(posedge clk_in);
		addr_out <= a;
		wdata_out <= d;
		be_out <= be;
		rd_out <= rnw;
		wr_out <= !rnw;
		do @(posedge clk_in); while (wait_in !== 1'b0);
		q = rdata_in;
		rd_out <= 1'b0;
		wr_out <= 1'b0;
		wdata_out <= ~d; // Stale data inverted so nobody leans on it
	endtask : xfer
endmodule : acss_host_model
`default_nettype wire

// File: sim/acss_seq_chk.sv
// Checker for the acquisition sequencer; sees its ports only.
// Assumes one clock and the synchronous active-low reset.
`timescale 1ns/10ps
`default_nettype none
module acss_seq_chk import acss_pkg::*; #(
	parameter int CAL_CYCLES = acss_pkg::ACSS_CAL_CYC // Calibration length in cycles
) (
	input wire logic        core_clk_in,         // Clock
	input wire logic        resetn_in,           // Reset
	input wire logic [7:0]  avs_address_in,      // Address
	input wire logic        avs_read_in,         // Read
	input wire logic        avs_write_in,        // Write
	input wire logic [31:0] avs_writedata_in,    // Write data
	input wire logic [3:0]  avs_byteenable_in,   // Byte enables
	input wire logic [31:0] avs_readdata_out,    // Read data
	input wire logic        avs_waitrequest_out, // Wait request
	input wire logic        cmd_forward_out,     // Forward pulse
	input wire acss_eng_t   eng_out,             // Engines
	input wire logic [31:0] coef_used_out        // Coefficient
);
	int cal_cnt_q;
	// Length of the running calibration, counted in helper logic
	always_ff @(posedge core_clk_in) begin
		if (!resetn_in || !eng_out.cal_src) cal_cnt_q <= 0;
		else cal_cnt_q <= cal_cnt_q + 1;
	end
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!resetn_in);
	sequence s_wr_acc; avs_write_in && !avs_waitrequest_out; endsequence
	sequence s_rd_ctrl; avs_read_in && !avs_waitrequest_out && avs_address_in == ACSS_CTRL_OFS; endsequence
	property p_fwd_after; s_wr_acc |=> cmd_forward_out; endproperty
	property p_fwd_cause; cmd_forward_out |-> $past(avs_write_in && !avs_waitrequest_out); endproperty
	property p_start_zero; s_rd_ctrl |-> !avs_readdata_out[ACSS_START_BIT]; endproperty
	property p_pyramid; eng_out.adc_run && eng_out.comp_run |-> eng_out.pyramid; endproperty
	property p_hv_quiet; eng_out.hv_recover |-> !eng_out.adc_run && !eng_out.comp_run; endproperty
	property p_cal_adc; eng_out.cal_src |-> eng_out.adc_run && !eng_out.comp_run; endproperty
	property p_coef; coef_used_out == ACSS_FACT_COEF || coef_used_out == ACSS_CAL_COEF; endproperty
	property p_cal_len; $fell(eng_out.cal_src) |-> cal_cnt_q >= CAL_CYCLES - 2 && cal_cnt_q <= CAL_CYCLES + 2;
	endproperty
	a_fwd_after: assert property (p_fwd_after) else $error("no forward after write");
	a_fwd_cause: assert property (p_fwd_cause) else $error("forward without write");
	a_start_zero: assert property (p_start_zero) else $error("start bit read as one");
	a_pyramid: assert property (p_pyramid) else $error("combined run not pyramid");
	a_hv_quiet: assert property (p_hv_quiet) else $error("engine busy in recovery");
	a_cal_adc: assert property (p_cal_adc) else $error("calibration engine mix");
	a_coef: assert property (p_coef) else $error("unknown coefficient");
	a_cal_len: assert property (p_cal_len) else $error("calibration length off");
endmodule : acss_seq_chk
bind acss_seq acss_seq_chk #(.CAL_CYCLES(CAL_CYCLES)) u_chk (.core_clk_in(core_clk_in),
	.resetn_in(resetn_in), .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
	.avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
	.avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
	.cmd_forward_out(cmd_forward_out), .eng_out(eng_out), .coef_used_out(coef_used_out));
`default_nettype wire

// File: sim/tb.sv
// Self-checking bench for the acquisition sequencer.
// Assumes the host model drives the register bus; calibration shortened.
`timescale 1ns/10ps
`default_nettype none
module tb;
	import acss_pkg::*;
	logic core_clk_in = 1'b0;
	logic resetn_in = 1'b0;
	logic [7:0] addr;
	logic rd_s, wr_s, wreq, fwd, hv_q = 1'b0;
	logic [31:0] wdat, rdat, coef;
	logic [3:0] be;
	acss_eng_t eng;
	int error_cnt = 0, n_checks = 0;
	int fwd_n = 0, comp_n = 0, adc_n = 0, hv_n = 0, bad_n = 0;
	always #4 core_clk_in = ~core_clk_in;
	acss_host_model host (.clk_in(core_clk_in), .wait_in(wreq), .rdata_in(rdat), .addr_out(addr),
		.rd_out(rd_s), .wr_out(wr_s), .wdata_out(wdat), .be_out(be));
	acss_seq #(.CAL_CYCLES(50)) DUT (.core_clk_in(core_clk_in), .resetn_in(resetn_in),
		.avs_address_in(addr), .avs_read_in(rd_s), .avs_write_in(wr_s), .avs_writedata_in(wdat),
		.avs_byteenable_in(be), .avs_readdata_out(rdat), .avs_waitrequest_out(wreq),
		.cmd_forward_out(fwd), .eng_out(eng), .coef_used_out(coef));
	// Free-running activity counters; scenarios compare deltas, except bad_n which is checked as a total
	always @(posedge core_clk_in) begin
		fwd_n <= fwd_n + int'(fwd === 1'b1);
		comp_n <= comp_n + int'(eng.comp_run === 1'b1);
		adc_n <= adc_n + int'(eng.adc_run === 1'b1);
		hv_n <= hv_n + int'(eng.hv_recover === 1'b1 && hv_q !== 1'b1);
		hv_q <= eng.hv_recover;
		bad_n <= bad_n + int'(eng.adc_run === 1'b1 && eng.comp_run === 1'b1 && eng.pyramid !== 1'b1);
	end
	task automatic report_and_stop;
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : report_and_stop
	task automatic chk_w(input logic [31:0] got, input logic [31:0] exp, input string m);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
		end
	endtask : chk_w
	task automatic chk_n(input int got, input int exp, input string m);
		n_checks++;
		if (got != exp) begin
			error_cnt++;
			$display("unexpected at %0t: %s got %0d exp %0d", $time, m, got, exp);
		end
	endtask : chk_n
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] b);
		logic [31:0] q;
		host.xfer(1'b0, a, d, b, q);
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		host.xfer(1'b1, a, 32'h0, 4'hF, q);
	endtask : rd
	// Set up, clear the complete flag, then write the control word
	task automatic launch(input logic [31:0] cfg, input logic [31:0] al, input logic [31:0] ctl);
		wr(ACSS_CFG_OFS, cfg, 4'hF);
		wr(ACSS_ALERT_OFS, al, 4'hF);
		wr(ACSS_STAT_OFS, 32'h1, 4'hF);
		wr(ACSS_CTRL_OFS, ctl, 4'hF);
	endtask : launch
	// Polls sparsely so the bus traffic stays small against the run
	task automatic wait_done;
		logic [31:0] q;
		q = 32'h0;
		for (int i = 0; i < 5000 && q[0] !== 1'b1; i++) begin
			repeat (16) @(posedge core_clk_in);
			rd(ACSS_STAT_OFS, q);
		end
		chk_w(q & 32'h1, 32'h1, "complete flag");
	endtask : wait_done
	task automatic t_reset;
		logic [31:0] q;
		rd(ACSS_STAT_OFS, q);
		chk_w(q, 32'h0, "status after reset");
		chk_w(coef, ACSS_FACT_COEF, "coef after reset");
	endtask : t_reset
	task automatic t_cal;
		logic [31:0] q;
		int f0;
		f0 = fwd_n;
		launch(32'hFFFF_FFFF, 32'h0, 32'h7);
		wr(ACSS_CTRL_OFS, 32'h100, 4'h2);
		repeat (2) @(posedge core_clk_in);
		chk_n(fwd_n - f0, 5, "forwards");
		wait_done;
		chk_w(coef, ACSS_FACT_COEF, "apply ignored");
		rd(ACSS_COEF_OFS, q);
		chk_w(q, ACSS_CAL_COEF, "stored coef");
		rd(ACSS_FACT_OFS, q);
		chk_w(q, ACSS_FACT_COEF, "factory coef");
		wr(ACSS_CTRL_OFS, 32'h0, 4'h1);
		rd(ACSS_CTRL_OFS, q);
		chk_w(q & 32'h6, 32'h6, "type kept");
		wr(ACSS_CTRL_OFS, 32'h100, 4'h2);
		repeat (2) @(posedge core_clk_in);
		chk_w(coef, ACSS_CAL_COEF, "apply on");
	endtask : t_cal
	task automatic t_comb;
		logic [31:0] q;
		int h0, c0;
		h0 = hv_n;
		c0 = comp_n;
		launch(32'h0010_4001, 32'h0000_000F, 32'h0000_0095);
		wait_done;
		rd(ACSS_CTRL_OFS, q);
		chk_w(q & 32'h1, 32'h0, "start bit");
		rd(ACSS_TIME_OFS, q);
		chk_w(q, 32'(ACSS_INIT_OVS_CYC + 4 * (ACSS_CELL_CYC + ACSS_BLK_CYC + ACSS_AUX_CYC)
			+ 3 * ACSS_HVREC_CYC), "time");
		chk_n(hv_n - h0, 3, "recoveries");
		chk_n(int'(comp_n > c0), 1, "comparator ran");
		chk_n(bad_n, 0, "ramp order");
	endtask : t_comb
	task automatic t_diag;
		logic [31:0] q;
		int h0, c0, a0;
		int dc[4] = '{ACSS_DTEMP_CYC, ACSS_VREF_CYC, ACSS_DAC_CYC, ACSS_DOTH_CYC};
		for (int d = 0; d < 4; d++) begin
			h0 = hv_n;
			c0 = comp_n;
			a0 = adc_n;
			launch(32'h0020_0001 | (32'(d) << 22), 32'h0, 32'h5);
			wait_done;
			rd(ACSS_TIME_OFS, q);
			chk_w(q, 32'(ACSS_INIT_ONE_CYC + ACSS_CELL_CYC + dc[d]), "diag time");
			chk_n(comp_n - c0, 0, "comparator idle");
			chk_n(int'(adc_n > a0), 1, "adc ran");
			chk_n(hv_n - h0, 0, "no recovery");
		end
	endtask : t_diag
	// Main sequence
	initial begin
		repeat (5) @(posedge core_clk_in);
		resetn_in <= 1'b1;
		t_reset;
		t_cal;
		t_comb;
		t_diag;
		report_and_stop;
	end
	// Hang guard: the scenarios need about 91000 cycles, so this leaves a margin of about 7000 cycles
	initial begin
		repeat (98000) @(posedge core_clk_in);
		error_cnt++;
		report_and_stop;
	end
endmodule : tb
`default_nettype wire
